// ==== rtl/period_match_timer8.sv ====
// 8-bit timer with period match, prescaler, postscaler and AXI4-Lite registers
// assumes I_CLOCK is the oscillator clock and one AXI4-Lite master
//
// Behaviour
// - the counter is an 8-bit register that steps up on each prescaled tick, or clears to zero on a tick while it matches.
// - an 8-bit period register holds the value the counter is compared against.
// - software can read and write counter and period registers at any time.
// - the input is the clock divided by four, then prescaled by 1, 4 or 16 per bits 1:0.
// - a match event occurs on each prescaled tick while the counter equals the period register.
// - matches pass a 4-bit postscaler dividing by 1 to 16 before the interrupt.
// - each postscaler output sets the latched match interrupt flag in bit 1.
// - clearing the run enable in control bit 2 stops the timer, setting it runs it.
// - every reset clears the counter register.
// - prescaler and postscaler clear on counter writes, control writes and reset.
// - writing the control register leaves the counter value alone.
// - count and match timing are exported as the pwm time base.
// - the match output is offered to the serial port as a shift clock source.
// - control sits at index 12h: bit 7 zero, 6:3 postscale, 2 run, 1:0 prescale, reset 0.
// - the postscale field value plus one is the division ratio.
`timescale 1ns/10ps
module period_match_timer8 (
    input wire logic I_CLOCK, // core clock
    input wire logic I_NRST, // async reset, active low
    input wire logic [9:0] I_AWADDR, // write address
    input wire logic I_AWVALID, // write address valid
    output logic O_AWREADY, // write address ready
    input wire logic [31:0] I_WDATA, // write data
    input wire logic [3:0] I_WSTRB, // write strobes
    input wire logic I_WVALID, // write data valid
    output logic O_WREADY, // write data ready
    output logic [1:0] O_BRESP, // write response
    output logic O_BVALID, // write response valid
    input wire logic I_BREADY, // write response ready
    input wire logic [9:0] I_ARADDR, // read address
    input wire logic I_ARVALID, // read address valid
    output logic O_ARREADY, // read address ready
    output logic [31:0] O_RDATA, // read data
    output logic [1:0] O_RRESP, // read response
    output logic O_RVALID, // read data valid
    input wire logic I_RREADY, // read data ready
    output period_match_timer8_pkg::timebase_t O_TIMEBASE, // pwm time base
    output logic O_SHIFT_CLOCK, // serial port shift clock source
    output logic O_IRQ // interrupt, level
);

    // ==========================================================
    // register state
    period_match_timer8_pkg::control_t control_reg;
    logic [7:0] count_reg;
    logic [7:0] period_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] instr_div_reg;
    logic [3:0] prescale_reg;
    logic [3:0] postscale_reg;

    // ==========================================================
    // write channel
    logic [9:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic wr_fire;
    logic wr_hit;
    logic wr_control;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic wr_mask;

    assign wr_fire = aw_held_reg && w_held_reg && !O_BVALID;
    assign wr_control = wr_fire && awaddr_reg == period_match_timer8_pkg::ADDR_CONTROL
        && wstrb_reg[0];
    assign wr_count = wr_fire && awaddr_reg == period_match_timer8_pkg::ADDR_COUNT
        && wstrb_reg[0];
    assign wr_period = wr_fire && awaddr_reg == period_match_timer8_pkg::ADDR_PERIOD
        && wstrb_reg[0];
    assign wr_status = wr_fire && awaddr_reg == period_match_timer8_pkg::ADDR_IRQ_STATUS
        && wstrb_reg[0];
    assign wr_mask = wr_fire && awaddr_reg == period_match_timer8_pkg::ADDR_IRQ_MASK
        && wstrb_reg[0];
    assign wr_hit = awaddr_reg == period_match_timer8_pkg::ADDR_CONTROL
        || awaddr_reg == period_match_timer8_pkg::ADDR_COUNT
        || awaddr_reg == period_match_timer8_pkg::ADDR_PERIOD
        || awaddr_reg == period_match_timer8_pkg::ADDR_IRQ_STATUS
        || awaddr_reg == period_match_timer8_pkg::ADDR_IRQ_MASK;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 10'h000;
            O_AWREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_held_reg && !(I_AWVALID && O_AWREADY);
            if (I_AWVALID && O_AWREADY) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {I_AWADDR[9:2], 2'h0};
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            O_WREADY <= 1'b0;
        end else begin
            O_WREADY <= !w_held_reg && !(I_WVALID && O_WREADY);
            if (I_WVALID && O_WREADY) begin
                w_held_reg <= 1'b1;
                wdata_reg <= I_WDATA;
                wstrb_reg <= I_WSTRB;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= period_match_timer8_pkg::OKAY;
        end else if (wr_fire) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_hit ? period_match_timer8_pkg::OKAY : period_match_timer8_pkg::SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ==========================================================
    // read channel
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case ({I_ARADDR[9:2], 2'h0})
            period_match_timer8_pkg::ADDR_CONTROL: rd_word[7:0] = {1'b0, control_reg[6:0]};
            period_match_timer8_pkg::ADDR_COUNT: rd_word[7:0] = count_reg;
            period_match_timer8_pkg::ADDR_PERIOD: rd_word[7:0] = period_reg;
            period_match_timer8_pkg::ADDR_IRQ_STATUS: rd_word[1:0] = irq_status_reg;
            period_match_timer8_pkg::ADDR_IRQ_MASK: rd_word[1:0] = irq_mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= period_match_timer8_pkg::OKAY;
        end else begin
            O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_word;
                O_RRESP <= rd_hit ? period_match_timer8_pkg::OKAY
                    : period_match_timer8_pkg::SLVERR;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control and period registers
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            control_reg <= period_match_timer8_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            control_reg <= {1'b0, wdata_reg[6:0]};
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            period_reg <= period_match_timer8_pkg::PERIOD_RESET;
        end else if (wr_period) begin
            period_reg <= wdata_reg[7:0];
        end
    end

    // ==========================================================
    // clock division and prescaler
    logic instr_tick;
    logic pre_tick;
    logic scaler_clear;
    logic [3:0] pre_limit;
    logic match;
    logic post_tick;

    assign scaler_clear = wr_count || wr_control;
    assign instr_tick = control_reg.run_enable
        && instr_div_reg == period_match_timer8_pkg::INSTR_DIV;

    always_comb begin
        case (control_reg.prescale_sel)
            2'h0: pre_limit = period_match_timer8_pkg::PRE_DIV1;
            2'h1: pre_limit = period_match_timer8_pkg::PRE_DIV4;
            default: pre_limit = period_match_timer8_pkg::PRE_DIV16;
        endcase
    end

    assign pre_tick = instr_tick && prescale_reg == pre_limit;

    // divider stopped while not running to save power
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            instr_div_reg <= 2'h0;
        end else if (scaler_clear || !control_reg.run_enable) begin
            instr_div_reg <= 2'h0;
        end else begin
            instr_div_reg <= instr_div_reg + 2'h1;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            prescale_reg <= 4'h0;
        end else if (scaler_clear || pre_tick) begin
            prescale_reg <= 4'h0;
        end else if (instr_tick) begin
            prescale_reg <= prescale_reg + 4'h1;
        end
    end

    // ==========================================================
    // counter and match
    assign match = count_reg == period_reg;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            count_reg <= period_match_timer8_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_reg <= wdata_reg[7:0];
        end else if (pre_tick) begin
            count_reg <= match ? 8'h00 : count_reg + 8'h01;
        end
    end

    // ==========================================================
    // postscaler
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            postscale_reg <= 4'h0;
        end else if (scaler_clear) begin
            postscale_reg <= 4'h0;
        end else if (pre_tick && match) begin
            postscale_reg <= post_tick ? 4'h0 : postscale_reg + 4'h1;
        end
    end

    assign post_tick = postscale_reg == control_reg.postscale_sel;

    // ==========================================================
    // interrupts and exported time base
    logic post_event;

    assign post_event = pre_tick && match && !scaler_clear && post_tick;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg[0] <= 1'b0;
            // set wins over a write-one clear
            if (post_event) begin
                irq_status_reg[1] <= 1'b1;
            end else if (wr_status && wdata_reg[1]) begin
                irq_status_reg[1] <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq_mask_reg <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_reg <= {wdata_reg[1], 1'b0};
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_IRQ <= 1'b0;
            O_TIMEBASE <= '0;
            O_SHIFT_CLOCK <= 1'b0;
        end else begin
            O_IRQ <= |(irq_status_reg & irq_mask_reg);
            O_TIMEBASE <= {count_reg, match, pre_tick};
            O_SHIFT_CLOCK <= pre_tick && match;
        end
    end

endmodule

// ==== rtl/period_match_timer8_pkg.sv ====
// package for the period match timer: register map, fields, reset values
// assumes an AXI4-Lite master with 32-bit data and aligned word access
package period_match_timer8_pkg;

    // ==========================================================
    // register map
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_COUNT = 8'h13;
    localparam logic [7:0] IDX_PERIOD = 8'h14;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h15;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h16;
    localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
    localparam logic [9:0] ADDR_COUNT = {IDX_COUNT, 2'h0};
    localparam logic [9:0] ADDR_PERIOD = {IDX_PERIOD, 2'h0};
    localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};

    // ==========================================================
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [1:0] OKAY = 2'h0;
    localparam logic [1:0] SLVERR = 2'h2;

    // ==========================================================
    // prescale ratios minus one
    localparam logic [3:0] PRE_DIV1 = 4'h0;
    localparam logic [3:0] PRE_DIV4 = 4'h3;
    localparam logic [3:0] PRE_DIV16 = 4'hf;
    // core clocks per instruction clock minus one
    localparam logic [1:0] INSTR_DIV = 2'h3;

    // control register layout, bit 7 reads zero
    typedef struct packed {
        logic unused_7;
        logic [3:0] postscale_sel;
        logic run_enable;
        logic [1:0] prescale_sel;
    } control_t;

    // time base output to the pwm unit
    typedef struct packed {
        logic [7:0] count;
        logic match;
        logic tick;
    } timebase_t;

endpackage

// ==== testbench/period_match_timer8_monitor.sv ====
// port checker for the period match timer
// assumes it is bound to period_match_timer8 and sees only its ports
`timescale 1ns/10ps
module period_match_timer8_monitor (
    input wire logic I_CLOCK, // core clock
    input wire logic I_NRST, // async reset, active low
    input wire logic I_AWVALID, // write address valid
    input wire logic O_AWREADY, // write address ready
    input wire logic I_WVALID, // write data valid
    input wire logic [1:0] O_BRESP, // write response
    input wire logic O_BVALID, // write response valid
    input wire logic I_BREADY, // write response ready
    input wire logic [31:0] O_RDATA, // read data
    input wire logic O_RVALID, // read data valid
    input wire logic I_RREADY, // read data ready
    input period_match_timer8_pkg::timebase_t O_TIMEBASE, // pwm time base
    input wire logic O_SHIFT_CLOCK, // shift clock source
    input wire logic O_IRQ // interrupt
);
    // ==========================================================
    // recent writes and shift pulses
    logic [5:0] wr_hist;
    logic [5:0] sh_hist;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) wr_hist <= 6'h00;
        else wr_hist <= {wr_hist[4:0], I_WVALID};
    end
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) sh_hist <= 6'h00;
        else sh_hist <= {sh_hist[4:0], O_SHIFT_CLOCK};
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    property p_bvalid_hold;
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped early");
    property p_rvalid_hold;
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read data dropped early");
    property p_rdata_width;
        O_RVALID |-> O_RDATA[31:8] == 24'h000000;
    endproperty
    a_rdata_width: assert property (p_rdata_width)
        else $error("read data upper bits set");
    property p_aw_take;
        I_AWVALID && O_AWREADY |=> !O_AWREADY;
    endproperty
    a_aw_take: assert property (p_aw_take)
        else $error("write address ready held");
    property p_tick_spacing;
        O_TIMEBASE.tick |=> !O_TIMEBASE.tick [*3];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("ticks closer than four clocks");
    property p_shift_spacing;
        O_SHIFT_CLOCK |=> !O_SHIFT_CLOCK [*3];
    endproperty
    a_shift_spacing: assert property (p_shift_spacing)
        else $error("shift pulses too close");
    property p_count_step;
        wr_hist == 6'h00 && O_TIMEBASE.count != $past(O_TIMEBASE.count)
        |-> O_TIMEBASE.count == 8'($past(O_TIMEBASE.count) + 8'h01)
        || O_TIMEBASE.count == 8'h00;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count moved by other than one");
    property p_irq_cause;
        $rose(O_IRQ) |-> (sh_hist != 6'h00) || (wr_hist != 6'h00);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt rose without a match");
endmodule
bind period_match_timer8 period_match_timer8_monitor i_period_match_timer8_monitor (
    .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_TIMEBASE(O_TIMEBASE), .O_SHIFT_CLOCK(O_SHIFT_CLOCK), .O_IRQ(O_IRQ)
);

// ==== testbench/period_match_timer8_tb.sv ====
// self-checking bench for the period match timer
// assumes the bound port checker and a 50 MHz core clock
`timescale 1ns/10ps
module period_match_timer8_tb;
    localparam logic [9:0] ctl_addr = period_match_timer8_pkg::ADDR_CONTROL;
    localparam logic [9:0] cnt_addr = period_match_timer8_pkg::ADDR_COUNT;
    localparam logic [9:0] per_addr = period_match_timer8_pkg::ADDR_PERIOD;
    localparam logic [9:0] sta_addr = period_match_timer8_pkg::ADDR_IRQ_STATUS;
    localparam logic [9:0] msk_addr = period_match_timer8_pkg::ADDR_IRQ_MASK;
    localparam logic [1:0] okay = period_match_timer8_pkg::OKAY;
    localparam logic [1:0] slverr = period_match_timer8_pkg::SLVERR;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    // raise bready and rready only after the answer, so the slave must hold it
    logic hold_ready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, shift_clk, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    period_match_timer8_pkg::timebase_t timebase;
    int miscompares = 0;
    int samples_checked = 0;
    period_match_timer8 i_period_match_timer8 (
        .I_CLOCK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_TIMEBASE(timebase), .O_SHIFT_CLOCK(shift_clk), .O_IRQ(irq)
    );
    // ==========================================================
    // bus cycles and comparison
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !hold_ready;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) miscompares++;
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !hold_ready;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) miscompares++;
    endtask
    task automatic wrc(input logic [9:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", {30'h0, r}, {30'h0, okay});
    endtask
    task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, d, e);
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic wait_shift(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!shift_clk && c < 2000);
        if (c >= 2000) miscompares++;
    endtask
    // ==========================================================
    // scenarios
    task automatic test_reset;
        logic [1:0] r;
        rdc("control", ctl_addr, 32'h0, okay);
        rdc("count", cnt_addr, 32'h0, okay);
        rdc("period", per_addr, 32'hff, okay);
        rdc("status", sta_addr, 32'h0, okay);
        rdc("mask", msk_addr, 32'h0, okay);
        rdc("unmapped", 10'h3fc, 32'h0, slverr);
        wr(10'h3fc, 8'h55, r);
        chk("unmapped bresp", {30'h0, r}, {30'h0, slverr});
        $display("test reset done");
    endtask
    task automatic test_regs;
        hold_ready = 1'b1;
        wrc(ctl_addr, 8'hfb);
        rdc("control", ctl_addr, 32'h7b, okay);
        wrc(per_addr, 8'h5a);
        rdc("period", per_addr, 32'h5a, okay);
        wrc(cnt_addr, 8'ha5);
        wrc(ctl_addr, 8'h00);
        rdc("count", cnt_addr, 32'ha5, okay);
        repeat (40) @(posedge clk);
        rdc("stopped count", cnt_addr, 32'ha5, okay);
        hold_ready = 1'b0;
        $display("test regs done");
    endtask
    task automatic test_prescale;
        int c;
        wrc(per_addr, 8'h03);
        wrc(cnt_addr, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wrc(ctl_addr, 8'h04 | 8'(i));
            wait_shift(c);
            wait_shift(c);
            chk("interval", 32'(c), (i == 0) ? 32'd16 : (i == 1) ? 32'd64 : 32'd256);
            chk("match timebase", {22'h0, timebase}, {22'h0, 8'h03, 2'h3});
        end
        $display("test prescale done");
    endtask
    task automatic test_postscale;
        int c;
        wrc(ctl_addr, 8'h00);
        wrc(per_addr, 8'h01);
        wrc(cnt_addr, 8'h00);
        wrc(msk_addr, 8'h02);
        wrc(sta_addr, 8'h02);
        wrc(ctl_addr, 8'h14);
        for (int k = 1; k < 4; k++) begin
            wait_shift(c);
            repeat (4) @(posedge clk);
            chk("irq", {31'h0, irq}, {31'h0, k == 3});
        end
        rdc("status", sta_addr, 32'h02, okay);
        wrc(sta_addr, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wrc(msk_addr, 8'h00);
        repeat (30) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdc("sticky status", sta_addr, 32'h02, okay);
        wrc(ctl_addr, 8'h00);
        $display("test postscale done");
    endtask
    task automatic test_clear;
        int c;
        wrc(per_addr, 8'h03);
        wrc(ctl_addr, 8'h07);
        wrc(cnt_addr, 8'h00);
        // let the prescaler run part way before the counter write
        repeat (20) @(posedge clk);
        wrc(cnt_addr, 8'h02);
        c = 0;
        while (timebase.count != 8'h02 && c < 100) begin
            @(posedge clk);
            c++;
        end
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!timebase.tick && c < 200);
        chk("first tick", 32'(c), 32'd63);
        chk("tick timebase", {22'h0, timebase}, {22'h0, 8'h02, 2'h1});
        // reset in mid-run with a nonzero count
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rdc("count after reset", cnt_addr, 32'h0, okay);
        rdc("control after reset", ctl_addr, 32'h0, okay);
        $display("test clear done");
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, sequence and watchdog
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset();
        test_regs();
        test_prescale();
        test_postscale();
        test_clear();
        stop_test();
    end
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule
